// ===== rtl/scda_top.sv
// Sampling clock delay adjust: manual, ramped and calibrated delay control.
// Assumes a plain register port and inputs synchronous to the sampling clock.
//
// Summary of operation
// - Done bit set only when enabled, finished
// - Status shows computed delay word, read-only
// - Invert bit inverts the sampling clock
// - Manual coarse field sets coarse delay
// - Fine field sets fine delay, resets zero
// - Ramp steps one or four codes/256 cycles
// - No ramp: apply within 1024 cycles
// - Ramp stops when applied equals written
// - Calibration enabled ignores manual control
// - Enable rising edge starts new calibration
`default_nettype none

module scda_top #(
  parameter int unsigned RAMP_PERIOD = scda_pkg::RAMP_PERIOD,
  parameter int unsigned CAL_EDGES = scda_pkg::CAL_EDGES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [9:0] addr,
  input wire logic [23:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic sysref,
  input wire logic [16:0] phase,
  output logic [23:0] rd_data_q,
  output var scda_pkg::scda_delay_t delay_q,
  output logic irq_q
);

  localparam int unsigned TW = $clog2(RAMP_PERIOD);

  generate
    if (RAMP_PERIOD < 2 || (RAMP_PERIOD & (RAMP_PERIOD - 1)) != 0) begin : g_chk
      $error("RAMP_PERIOD must be a power of two");
    end
  endgenerate

  // ****************************************
  // Register file
  // ****************************************
  logic cal_en_q, cal_en_d;
  scda_pkg::scda_delay_t ctrl_q, ctrl_d;
  scda_pkg::scda_ramp_t ramp_q, ramp_d;
  logic [1:0] stat_q, stat_d;
  logic [1:0] mask_q, mask_d;
  logic [23:0] rd_data_d;
  logic irq_d;
  logic cal_start;
  logic cal_done;
  logic [16:0] cal_word;
  logic done_view;
  logic [1:0] events;

  logic wr_cal, wr_ctrl, wr_ramp, wr_stat, wr_mask;

  always_comb begin
    wr_cal = 1'b0;
    wr_ctrl = 1'b0;
    wr_ramp = 1'b0;
    wr_stat = 1'b0;
    wr_mask = 1'b0;
    if (!wr_en) begin
      wr_cal = 1'b0;
    end else if (addr == scda_pkg::OFF_CAL_EN) begin
      wr_cal = 1'b1;
    end else if (addr == scda_pkg::OFF_DELAY_CTRL) begin
      wr_ctrl = 1'b1;
    end else if (addr == scda_pkg::OFF_RAMP_CTRL) begin
      wr_ramp = 1'b1;
    end else if (addr == scda_pkg::OFF_IRQ_STATUS) begin
      wr_stat = 1'b1;
    end else if (addr == scda_pkg::OFF_IRQ_MASK) begin
      wr_mask = 1'b1;
    end
  end

  assign cal_start = wr_cal && wdata[scda_pkg::CAL_EN_BIT] && !cal_en_q;
  assign done_view = cal_done && cal_en_q;

  always_comb begin
    cal_en_d = wr_cal ? wdata[scda_pkg::CAL_EN_BIT] : cal_en_q;
    ctrl_d = wr_ctrl ? scda_pkg::scda_delay_t'(wdata[16:0]) : ctrl_q;
    ramp_d = wr_ramp ? scda_pkg::scda_ramp_t'(wdata[1:0]) : ramp_q;
    mask_d = wr_mask ? wdata[1:0] : mask_q;
    // Set wins over a write-one clear in the same cycle
    stat_d = (stat_q & ~(wr_stat ? wdata[1:0] : 2'h0)) | events;
    irq_d = |(stat_d & mask_d);
    rd_data_d = 24'h000000;
    if (!rd_en) begin
      rd_data_d = 24'h000000;
    end else if (addr == scda_pkg::OFF_CAL_EN) begin
      rd_data_d[scda_pkg::CAL_EN_BIT] = cal_en_q;
    end else if (addr == scda_pkg::OFF_CAL_RESULT) begin
      rd_data_d[scda_pkg::WORD_W-1:0] = cal_word;
      rd_data_d[scda_pkg::DONE_BIT] = done_view;
    end else if (addr == scda_pkg::OFF_DELAY_CTRL) begin
      rd_data_d[16:0] = ctrl_q;
    end else if (addr == scda_pkg::OFF_RAMP_CTRL) begin
      rd_data_d[1:0] = ramp_q;
    end else if (addr == scda_pkg::OFF_IRQ_STATUS) begin
      rd_data_d[1:0] = stat_q;
    end else if (addr == scda_pkg::OFF_IRQ_MASK) begin
      rd_data_d[1:0] = mask_q;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cal_en_q <= 1'b0;
      ctrl_q <= scda_pkg::DELAY_RST;
      ramp_q <= scda_pkg::RAMP_RST;
      stat_q <= 2'h0;
      mask_q <= 2'h0;
      rd_data_q <= 24'h000000;
      irq_q <= 1'b0;
    end else begin
      cal_en_q <= cal_en_d;
      ctrl_q <= ctrl_d;
      ramp_q <= ramp_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      rd_data_q <= rd_data_d;
      irq_q <= irq_d;
    end
  end

  // ****************************************
  // Calibration engine
  // ****************************************
  scda_cal_engine #(
    .EDGES(CAL_EDGES)
  ) u_cal (
    .clock(clock),
    .rst(rst),
    .enable(cal_en_q),
    .start(cal_start),
    .sysref(sysref),
    .phase(phase),
    .done_q(cal_done),
    .word_q(cal_word)
  );

  // ****************************************
  // Applied delay and coarse ramp
  // ****************************************
  logic [TW-1:0] tick_q, tick_d;
  logic tick_wrap;
  logic done_seen_q, done_seen_d;
  scda_pkg::scda_delay_t delay_d;
  logic [7:0] step, gap, coarse_next;

  assign tick_wrap = (tick_q == TW'(RAMP_PERIOD - 1));

  always_comb begin
    tick_d = tick_q + TW'(1);
    step = ramp_q.rate ? scda_pkg::STEP_FAST : scda_pkg::STEP_SLOW;
    gap = 8'h00;
    coarse_next = delay_q.coarse;
    if (ctrl_q.coarse > delay_q.coarse) begin
      gap = ctrl_q.coarse - delay_q.coarse;
      coarse_next = (gap <= step) ? ctrl_q.coarse : delay_q.coarse + step;
    end else if (ctrl_q.coarse < delay_q.coarse) begin
      gap = delay_q.coarse - ctrl_q.coarse;
      coarse_next = (gap <= step) ? ctrl_q.coarse : delay_q.coarse - step;
    end
    delay_d = delay_q;
    events = 2'h0;
    done_seen_d = done_view;
    if (cal_en_q) begin
      if (cal_done) begin
        delay_d = scda_pkg::scda_delay_t'(cal_word);
      end
    end else begin
      delay_d.inv = ctrl_q.inv;
      delay_d.fine = ctrl_q.fine;
      if (!ramp_q.en) begin
        delay_d.coarse = ctrl_q.coarse;
      end else if (tick_wrap) begin
        delay_d.coarse = coarse_next;
        events[scda_pkg::IRQ_RAMP_DONE] = (gap != 8'h00) && (coarse_next == ctrl_q.coarse);
      end
    end
    events[scda_pkg::IRQ_CAL_DONE] = done_view && !done_seen_q;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tick_q <= '0;
      done_seen_q <= 1'b0;
      delay_q <= scda_pkg::DELAY_RST;
    end else begin
      tick_q <= tick_d;
      done_seen_q <= done_seen_d;
      delay_q <= delay_d;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  property p_done_gated;
    rd_en && (addr == scda_pkg::OFF_CAL_RESULT) && !cal_en_q |=> !rd_data_q[scda_pkg::DONE_BIT];
  endproperty
  a_done_gated: assert property (p_done_gated)
    else $error("done read high while calibration off");

  property p_word_read;
    rd_en && (addr == scda_pkg::OFF_CAL_RESULT) |=> rd_data_q[16:0] == $past(cal_word);
  endproperty
  a_word_read: assert property (p_word_read)
    else $error("status word differs from computed word");

  property p_invert;
    !cal_en_q |=> delay_q.inv == $past(ctrl_q.inv);
  endproperty
  a_invert: assert property (p_invert)
    else $error("inversion not applied");

  property p_fine;
    !cal_en_q |=> delay_q.fine == $past(ctrl_q.fine);
  endproperty
  a_fine: assert property (p_fine)
    else $error("fine delay not applied");

  // The written code sits in the register one edge after the strobe, then reaches the output
  property p_direct_coarse;
    !cal_en_q && !ramp_q.en && wr_ctrl ##1 !cal_en_q && !ramp_q.en
      |=> delay_q.coarse == $past(ctrl_q.coarse);
  endproperty
  a_direct_coarse: assert property (p_direct_coarse)
    else $error("coarse write not applied in time");

  property p_hold_between_ticks;
    !cal_en_q && ramp_q.en && !tick_wrap |=> $stable(delay_q.coarse);
  endproperty
  a_hold_between_ticks: assert property (p_hold_between_ticks)
    else $error("coarse moved between ramp ticks");

  sequence s_fast_up;
    !cal_en_q && ramp_q.en && ramp_q.rate && tick_wrap
      && (ctrl_q.coarse > delay_q.coarse) && (gap > scda_pkg::STEP_FAST);
  endsequence

  property p_fast_step;
    s_fast_up |=> delay_q.coarse == $past(delay_q.coarse) + scda_pkg::STEP_FAST;
  endproperty
  a_fast_step: assert property (p_fast_step)
    else $error("fast ramp step is not four codes");

  sequence s_fast_down;
    !cal_en_q && ramp_q.en && ramp_q.rate && tick_wrap
      && (ctrl_q.coarse < delay_q.coarse) && (gap > scda_pkg::STEP_FAST);
  endsequence

  property p_fast_down;
    s_fast_down |=> delay_q.coarse == $past(delay_q.coarse) - scda_pkg::STEP_FAST;
  endproperty
  a_fast_down: assert property (p_fast_down)
    else $error("fast ramp down step is not four codes");

  property p_ramp_stop;
    !cal_en_q && ramp_q.en && (delay_q.coarse == ctrl_q.coarse) && !wr_ctrl ##1 !cal_en_q
      |-> $stable(delay_q.coarse);
  endproperty
  a_ramp_stop: assert property (p_ramp_stop)
    else $error("ramp moved past its target");

  property p_cal_overrides;
    cal_en_q && cal_done |=> delay_q == $past(cal_word);
  endproperty
  a_cal_overrides: assert property (p_cal_overrides)
    else $error("manual delay used during calibration");

  // A clear written in the same cycle must not swallow the event
  property p_ramp_event_kept;
    events[scda_pkg::IRQ_RAMP_DONE] |=> stat_q[scda_pkg::IRQ_RAMP_DONE];
  endproperty
  a_ramp_event_kept: assert property (p_ramp_event_kept)
    else $error("ramp done event lost");

  property p_cal_event;
    $rose(done_view) |=> stat_q[scda_pkg::IRQ_CAL_DONE];
  endproperty
  a_cal_event: assert property (p_cal_event)
    else $error("calibration done event lost");

endmodule

`default_nettype wire

// ===== rtl/scda_pkg.sv
// Constants and carrier types for the sampling clock delay adjust block.
// Assumes a single clock domain and a byte-style register address space.
`default_nettype none

package scda_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned DATA_W = 24;
  localparam logic [9:0] OFF_CAL_EN = 10'h2b0;
  localparam logic [9:0] OFF_CAL_RESULT = 10'h2b2;
  localparam logic [9:0] OFF_DELAY_CTRL = 10'h2b5;
  localparam logic [9:0] OFF_RAMP_CTRL = 10'h2b8;
  localparam logic [9:0] OFF_IRQ_STATUS = 10'h2ba;
  localparam logic [9:0] OFF_IRQ_MASK = 10'h2bb;

  // ****************************************
  // Field layout and reset values
  // ****************************************
  localparam int unsigned CAL_EN_BIT = 0;
  localparam int unsigned DONE_BIT = 17;
  localparam int unsigned WORD_W = 17;
  localparam int unsigned RAMP_EN_BIT = 0;
  localparam int unsigned RAMP_RATE_BIT = 1;
  localparam int unsigned IRQ_CAL_DONE = 0;
  localparam int unsigned IRQ_RAMP_DONE = 1;
  localparam int unsigned IRQ_W = 2;
  localparam logic [16:0] DELAY_RST = 17'h00000;
  localparam logic [1:0] RAMP_RST = 2'h0;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned RAMP_PERIOD = 256;
  localparam int unsigned APPLY_LIMIT = 1024;
  localparam logic [7:0] STEP_SLOW = 8'h01;
  localparam logic [7:0] STEP_FAST = 8'h04;
  localparam int unsigned CAL_EDGES = 4;

  typedef struct packed {
    logic inv;
    logic [7:0] coarse;
    logic [7:0] fine;
  } scda_delay_t;

  typedef struct packed {
    logic rate;
    logic en;
  } scda_ramp_t;

endpackage

`default_nettype wire

// ===== rtl/scda_cal_engine.sv
// Reference-edge calibration engine: measures the delay word against SYSREF.
// Assumes sysref and phase are synchronous to clock; phase comes from the
// analog phase detector and is captured on a reference edge.
`default_nettype none

module scda_cal_engine #(
  parameter int unsigned EDGES = scda_pkg::CAL_EDGES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic enable,
  input wire logic start,
  input wire logic sysref,
  input wire logic [16:0] phase,
  output logic done_q,
  output logic [16:0] word_q
);

  localparam int unsigned CW = $clog2(EDGES + 1);

  generate
    if (EDGES < 1) begin : g_chk
      $error("EDGES must be at least one");
    end
  endgenerate

  typedef enum logic [1:0] {
    SCDA_IDLE,
    SCDA_MEASURE,
    SCDA_DONE
  } scda_cal_state_t;

  scda_cal_state_t state_q, state_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic [16:0] word_d;
  logic sysref_q;
  logic done_d;
  logic rise;

  assign rise = sysref && !sysref_q;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    word_d = word_q;
    if (start) begin
      state_d = SCDA_MEASURE;
      cnt_d = '0;
    end else if (!enable) begin
      state_d = SCDA_IDLE;
    end else begin
      case (state_q)
        SCDA_MEASURE: begin
          if (rise) begin
            cnt_d = cnt_q + CW'(1);
            if (cnt_q == CW'(EDGES - 1)) begin
              word_d = phase;
              state_d = SCDA_DONE;
            end
          end
        end
        default: begin
        end
      endcase
    end
    done_d = (state_d == SCDA_DONE);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= SCDA_IDLE;
      cnt_q <= '0;
      word_q <= scda_pkg::DELAY_RST;
      sysref_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      word_q <= word_d;
      sysref_q <= sysref;
      done_q <= done_d;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence s_restart;
    start ##1 1'b1;
  endsequence

  property p_restart_clears;
    @(posedge clock) disable iff (rst)
    s_restart |-> !done_q && (state_q == SCDA_MEASURE);
  endproperty
  a_restart_clears: assert property (p_restart_clears)
    else $error("calibration did not restart");

  property p_off_not_done;
    @(posedge clock) disable iff (rst)
    !enable |=> !done_q;
  endproperty
  a_off_not_done: assert property (p_off_not_done)
    else $error("done set while calibration off");

endmodule

`default_nettype wire

// ===== sim/scda_top_tb.sv
// Self-checking bench for the sampling clock delay adjust block.
// Assumes scda_pkg and scda_top are compiled first; assertions live in the design.
`default_nettype none

module scda_top_tb;
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************
  // Signals and design instance
  // ****************************************
  // Short ramp period keeps the run brief; all ramp timing expectations derive from it
  localparam int RP = 16;
  typedef struct packed {
    logic [9:0] a;
    logic [23:0] w;
    logic [23:0] e;
  } scda_row_t;
  logic clock;
  logic rst;
  logic wr_en;
  logic rd_en;
  logic sysref;
  logic [9:0] addr;
  logic [23:0] wdata;
  logic [23:0] rd_data_q;
  logic [16:0] phase;
  logic irq_q;
  scda_pkg::scda_delay_t delay_q;
  int fail_count = 0;
  int tests_run = 0;
  int n;
  scda_row_t rows [6] = '{
    '{10'h2b8, 24'h0000ff, 24'h000003},
    '{10'h2b8, 24'h000000, 24'h000000},
    '{10'h2bb, 24'h000003, 24'h000003},
    '{10'h2bb, 24'h000000, 24'h000000},
    '{10'h2a0, 24'h123456, 24'h000000},
    '{10'h2b5, 24'h01a53c, 24'h01a53c}
  };

  scda_top #(.RAMP_PERIOD(RP), .CAL_EDGES(1)) u_dut (
    .clock(clock),
    .rst(rst),
    .addr(addr),
    .wdata(wdata),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .sysref(sysref),
    .phase(phase),
    .rd_data_q(rd_data_q),
    .delay_q(delay_q),
    .irq_q(irq_q)
  );

  // ****************************************
  // Bus and check tasks
  // ****************************************
  task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [23:0] d);
    @(posedge clock);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [9:0] a, input logic [23:0] e, input logic [23:0] m);
    @(posedge clock);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd_en <= 1'b0;
    #1;
    chk($sformatf("read %h", a), e & m, rd_data_q & m);
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask

  task automatic pulse();
    @(posedge clock);
    sysref <= 1'b1;
    @(posedge clock);
    sysref <= 1'b0;
  endtask

  task automatic wrap_up();
    $display("Checks run %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Follows the applied coarse code until it meets the target
  task automatic ramp_watch(input int tgt, input int step);
    int p;
    int gap;
    int want;
    bit first;
    // Let the edge that took the write settle before sampling
    #1;
    p = delay_q.coarse;
    gap = 0;
    first = 1'b1;
    for (int i = 0; i < 64 * RP && p != tgt; i++) begin
      cyc(1);
      gap++;
      if (delay_q.coarse !== 8'(p)) begin
        want = (tgt > p) ? p + ((tgt - p < step) ? tgt - p : step)
                         : p - ((p - tgt < step) ? p - tgt : step);
        chk("coarse step", 24'(want), 24'(delay_q.coarse));
        if (first) begin
          chk("first step late", 24'h0, 24'(gap > RP + 2));
        end else begin
          chk("ramp gap", 24'(RP), 24'(gap));
        end
        p = delay_q.coarse;
        gap = 0;
        first = 1'b0;
      end
    end
    if (p != tgt) begin
      fail_count++;
      $display("ERROR ramp expected %h seen %h", tgt, p);
      wrap_up();
    end
    cyc(RP + 4);
    chk("coarse hold", 24'(tgt), 24'(delay_q.coarse));
  endtask

  // ****************************************
  // Clock and stimulus
  // ****************************************
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  initial begin
    rst = 1'b1;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 10'h000;
    wdata = 24'h000000;
    sysref = 1'b0;
    phase = 17'h00000;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    cyc(1);
    chk("delay_q", 24'h0, 24'(delay_q));
    rd(10'h2b5, 24'h0, 24'hffffff);
    rd(10'h2b8, 24'h0, 24'hffffff);
    cyc(1);
    chk("rd_data_q idle", 24'h0, rd_data_q);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, rows[i].e, 24'hffffff);
    end
    for (n = 0; n < 1024 && delay_q !== 17'h1a53c; n++) cyc(1);
    chk("delay_q manual", 24'h01a53c, 24'(delay_q));
    // One code per write, as software should while the converter is busy
    wr(10'h2b5, 24'h01a43c);
    cyc(2);
    chk("delay_q one code down", 24'h01a43c, 24'(delay_q));
    wr(10'h2b5, 24'h01a53c);
    cyc(2);
    chk("delay_q one code up", 24'h01a53c, 24'(delay_q));
    // Slow ramp up, then interrupt raise, mask and clear
    wr(10'h2b8, 24'h1);
    wr(10'h2b5, 24'h01a73c);
    ramp_watch(8'ha7, 1);
    chk("delay_q ramp", 24'h01a73c, 24'(delay_q));
    rd(10'h2ba, 24'h2, 24'h3);
    chk("irq masked", 24'h0, 24'(irq_q));
    wr(10'h2bb, 24'h2);
    cyc(2);
    chk("irq raised", 24'h1, 24'(irq_q));
    wr(10'h2ba, 24'h2);
    cyc(2);
    chk("irq cleared", 24'h0, 24'(irq_q));
    rd(10'h2ba, 24'h0, 24'h3);
    // Fast ramp down and back up, each with a clamped last step
    wr(10'h2b8, 24'h3);
    wr(10'h2b5, 24'h019d3c);
    ramp_watch(8'h9d, 4);
    wr(10'h2b5, 24'h01a73c);
    ramp_watch(8'ha7, 4);
    chk("delay_q fast ramp", 24'h01a73c, 24'(delay_q));
    // Calibration, its done flag and restart
    @(posedge clock);
    phase <= 17'h15a5a;
    wr(10'h2b0, 24'h1);
    rd(10'h2b2, 24'h0, 24'h020000);
    pulse();
    cyc(3);
    rd(10'h2b2, 24'h035a5a, 24'hffffff);
    chk("delay_q cal", 24'h015a5a, 24'(delay_q));
    wr(10'h2b5, 24'h000000);
    cyc(3);
    chk("delay_q cal hold", 24'h015a5a, 24'(delay_q));
    rd(10'h2ba, 24'h1, 24'h1);
    wr(10'h2b0, 24'h1);
    cyc(2);
    rd(10'h2b2, 24'h020000, 24'h020000);
    wr(10'h2b0, 24'h0);
    rd(10'h2b2, 24'h0, 24'h020000);
    @(posedge clock);
    phase <= 17'h0a5a5;
    wr(10'h2b0, 24'h1);
    rd(10'h2b2, 24'h0, 24'h020000);
    pulse();
    cyc(3);
    rd(10'h2b2, 24'h02a5a5, 24'hffffff);
    chk("delay_q recal", 24'h00a5a5, 24'(delay_q));
    chk("irq before reset", 24'h1, 24'(irq_q));
    // Reset in mid-run
    @(posedge clock);
    rst <= 1'b1;
    cyc(2);
    chk("delay_q in reset", 24'h0, 24'(delay_q));
    chk("irq in reset", 24'h0, 24'(irq_q));
    @(posedge clock);
    rst <= 1'b0;
    rd(10'h2b0, 24'h0, 24'h1);
    rd(10'h2b5, 24'h0, 24'hffffff);
    wrap_up();
  end
endmodule

`default_nettype wire
